// ==== verification/power_stage_model.sv ====
module power_stage_model #(
  parameter int OFF_CYC = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // gate drives from the block
  input wire logic high_side_gate_drive,
  input wire logic low_side_gate_drive,
  // bench command
  input wire logic oc_cmd,
  // sensed back to the block
  output logic pwm_set_req,
  output logic valley_overcurrent
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] off_cnt_r;
  // valley current is only sensed while the low side conducts
  assign valley_overcurrent = oc_cmd & low_side_gate_drive;
  assign pwm_set_req = (off_cnt_r >= 8'(OFF_CYC));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      off_cnt_r <= 8'h00;
    end else if (high_side_gate_drive) begin
      off_cnt_r <= 8'h00;
    end else if (off_cnt_r != 8'hFF) begin
      off_cnt_r <= off_cnt_r + 8'h01;
    end
  end
endmodule

// ==== verification/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SS = 50;
  localparam int PGR = 40;
  localparam int UVD = 30;
  logic clk, rst_n, en, lock, hot, tight, wide, ov, uv, oc, set_req, voc;
  logic wr, rd, hs, ls, dis, ext, ocs, pg_o, pg_oe, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [9:0] ref_lvl;
  int bad_count, tests_run, n, k;
  ////////////////////////////////////////////////////////////////
  buck_fault_supervisor #(.SS_CYC(SS), .PGR_CYC(PGR), .UVD_CYC(UVD), .UVB_CYC(60)) DUT (
    .clk(clk), .rst_n(rst_n), .enable_in(en), .bias_lockout(lock), .over_temp(hot),
    .fb_in_tight_band(tight), .fb_in_wide_band(wide), .overvoltage_guard(ov),
    .undervoltage_guard(uv), .valley_overcurrent(voc), .pwm_set_req(set_req),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .high_side_gate_drive(hs), .low_side_gate_drive(ls), .discharge_on(dis),
    .offtime_extend(ext), .on_cycle_start(ocs), .ref_level(ref_lvl),
    .output_in_window_flag_o(pg_o), .output_in_window_flag_oe(pg_oe), .irq(irq));
  power_stage_model #(.OFF_CYC(4)) stage (
    .clk(clk), .rst_n(rst_n), .high_side_gate_drive(hs), .low_side_gate_drive(ls),
    .oc_cmd(oc), .pwm_set_req(set_req), .valley_overcurrent(voc));
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic st(input logic [2:0] s, input string what);
    rdr(8'h08);
    chk(what, {29'h0, s}, {29'h0, d[2:0]});
  endtask
  // cycles until the pin flag leaves the given level
  task automatic wait_oe(input logic lvl);
    while (pg_oe === lvl && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // counts cycles with the high side on
  task automatic count_hs(input int c);
    k = 0;
    repeat (c) begin
      @(posedge clk);
      #1;
      if (hs === 1'b1) k++;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chkb("dis", 1'b1, dis);
    chkb("hs", 1'b0, hs);
    chkb("ls", 1'b0, ls);
    chkb("pg oe", 1'b1, pg_oe);
    chkb("pg o", 1'b0, pg_o);
    chkb("irq", 1'b0, irq);
    chk("ref zero", 32'h0, {22'h0, ref_lvl});
    $display("test reset done");
  endtask
  task automatic t_start();
    @(posedge clk);
    en <= 1'b1;
    uv <= 1'b1;
    tight <= 1'b1;
    wide <= 1'b1;
    n = 0;
    repeat (20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chkb("ramp mid", 1'b1, ref_lvl > 10'h000 && ref_lvl < 10'h3FF);
    uv <= 1'b0;
    wait_oe(1'b1);
    chkb("pg early", 1'b1, n >= SS + PGR);
    chkb("pg late", 1'b1, n <= SS + PGR + 10);
    chkb("pg o", 1'b0, pg_o);
    chk("ref", 32'h3FF, {22'h0, ref_lvl});
    st(3'h2, "uv blanked");
    $display("test startup done");
  endtask
  task automatic t_pgfall();
    tight <= 1'b0;
    wide <= 1'b0;
    n = 0;
    wait_oe(1'b0);
    chkb("fall early", 1'b1, n >= 200);
    chkb("fall late", 1'b1, n <= 210);
    tight <= 1'b1;
    wide <= 1'b1;
    n = 0;
    wait_oe(1'b1);
    chkb("rise again", 1'b1, n >= PGR && n <= PGR + 10);
    $display("test pg fall done");
  endtask
  task automatic t_oc();
    oc <= 1'b1;
    cyc(10);
    count_hs(30);
    chk("held off", 0, k);
    chkb("extend", 1'b1, ext);
    chkb("no start", 1'b0, ocs);
    oc <= 1'b0;
    count_hs(20);
    chkb("resume", 1'b1, k > 0);
    rdr(8'h00);
    chkb("oc status", 1'b1, d[5]);
    wrr(8'h04, 32'h0);
    cyc(2);
    chkb("irq masked", 1'b0, irq);
    wrr(8'h04, 32'h20);
    cyc(2);
    chkb("irq set", 1'b1, irq);
    wrr(8'h00, 32'h3F);
    cyc(2);
    chkb("irq clear", 1'b0, irq);
    rdr(8'hFC);
    chk("unmapped", 0, d);
    $display("test overcurrent done");
  endtask
  task automatic t_halt();
    for (int i = 0; i < 2; i++) begin
      lock <= (i == 0);
      hot <= (i == 1);
      cyc(6);
      count_hs(30);
      chk("halt", 0, k);
      chkb("halt ls", 1'b0, ls);
      lock <= 1'b0;
      hot <= 1'b0;
      count_hs(SS + 40);
      chkb("restart", 1'b1, k > 0);
    end
    $display("test lockout and thermal done");
  endtask
  task automatic t_uv();
    uv <= 1'b1;
    cyc(20);
    uv <= 1'b0;
    cyc(20);
    st(3'h2, "uv short");
    uv <= 1'b1;
    cyc(UVD - 10);
    st(3'h2, "uv counting");
    cyc(20);
    st(3'h4, "uv latch");
    chkb("uv hs", 1'b0, hs);
    chkb("uv ls", 1'b0, ls);
    uv <= 1'b0;
    cyc(10);
    st(3'h4, "uv held");
    en <= 1'b0;
    cyc(6);
    st(3'h0, "uv cleared");
    chkb("dis", 1'b1, dis);
    $display("test undervoltage done");
  endtask
  task automatic t_ov();
    t_start();
    ov <= 1'b1;
    cyc(8);
    chkb("ov hs", 1'b0, hs);
    chkb("ov ls", 1'b1, ls);
    ov <= 1'b0;
    cyc(10);
    st(3'h3, "ov held");
    lock <= 1'b1;
    cyc(6);
    st(3'h0, "ov cleared");
    lock <= 1'b0;
    cyc(8);
    st(3'h1, "soft restart");
    $display("test overvoltage done");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #50000;
    bad_count++;
    test_done();
  end
  initial begin
    {clk, rst_n, en, lock, hot, tight, wide, ov, uv, oc, wr, rd} = 12'h000;
    addr = 8'h00;
    wdata = 32'h0;
    cyc(4);
    rst_n <= 1'b1;
    cyc(2);
    t_reset();
    t_start();
    t_pgfall();
    t_oc();
    t_halt();
    t_uv();
    t_ov();
    test_done();
  end
endmodule

// ==== verilog/buck_fault_defines.svh ====
`ifndef BUCK_FAULT_DEFINES_SVH
`define BUCK_FAULT_DEFINES_SVH

// clock rate in kHz
`define CLK_KHZ 100000
// times in microseconds, as printed
`define SOFTSTART_US 750
`define PG_RISE_US 1000
`define PG_FALL_US 2
`define UV_DELAY_US 1000
`define UV_BLANK_US 1200
// cycle counts derived from the rate
`define SOFTSTART_CYC ((`SOFTSTART_US * `CLK_KHZ) / 1000)
`define PG_RISE_CYC ((`PG_RISE_US * `CLK_KHZ) / 1000)
`define PG_FALL_CYC ((`PG_FALL_US * `CLK_KHZ) / 1000)
`define UV_DELAY_CYC ((`UV_DELAY_US * `CLK_KHZ) / 1000)
`define UV_BLANK_CYC ((`UV_BLANK_US * `CLK_KHZ) / 1000)
// interrupt status bit positions
`define EV_OV 0
`define EV_UV 1
`define EV_LOCK 2
`define EV_HOT 3
`define EV_PG_FALL 4
`define EV_OC 5
`define EV_N 6
// register offsets
`define REG_STATUS 8'h00
`define REG_MASK 8'h04
`define REG_STATE 8'h08
`define REG_CTRL 8'h0C

`endif

// ==== verilog/buck_fault_pkg.sv ====
package buck_fault_pkg;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_SOFTSTART = 3'b001,
    ST_RUN = 3'b010,
    ST_OV_LATCH = 3'b011,
    ST_UV_LATCH = 3'b100
  } seq_state_t;
endpackage

// ==== verilog/buck_fault_supervisor.sv ====
// The register offsets and the address-and-strobe port were decided locally.
`include "buck_fault_defines.svh"
// Summary of operation
// - power-good stays low and unsupervised until the soft-start ramp is done.
// - once the output is inside the -5%/+10% band, power-good rises after 1 ms.
// - once the output leaves the -10%/+15% band, power-good drops after 2 us.
// - power-good is only ever driven low; its high level comes from a pull-up.
// - while the high side is off, the off time is stretched while current exceeds the trip.
// - feedback above 120% latches high side off and low side on.
// - feedback below 70% starts the under-voltage delay counter.
// - after 1 ms of under-voltage both drivers latch off.
// - under-voltage is ignored until 1.2 ms after enable went high.
// - bias lockout stops switching without latching.
// - over-temperature stops switching without latching.
// - enable rising starts a 750 us reference ramp.
// - enable low keeps both drivers off and turns on the discharge path.
module buck_fault_supervisor #(
  parameter int SS_CYC = `SOFTSTART_CYC,
  parameter int PGR_CYC = `PG_RISE_CYC,
  parameter int UVD_CYC = `UV_DELAY_CYC,
  parameter int UVB_CYC = `UV_BLANK_CYC,
  parameter int REF_W = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // comparator and pin inputs
  input wire logic enable_in,
  input wire logic bias_lockout,
  input wire logic over_temp,
  input wire logic fb_in_tight_band,
  input wire logic fb_in_wide_band,
  input wire logic overvoltage_guard,
  input wire logic undervoltage_guard,
  input wire logic valley_overcurrent,
  // modulator request
  input wire logic pwm_set_req,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // outputs to drivers and pins
  output logic high_side_gate_drive,
  output logic low_side_gate_drive,
  output logic discharge_on,
  output logic offtime_extend,
  output logic on_cycle_start,
  output logic [REF_W-1:0] ref_level,
  output logic output_in_window_flag_o,
  output logic output_in_window_flag_oe,
  output logic irq
);
  localparam int CW = 32;

  ////////////////////////////////////////////////////////////////
  // input synchronisation
  sync_bus_if #(.W(8)) sbus ();
  assign sbus.raw = {valley_overcurrent, undervoltage_guard, overvoltage_guard,
                     fb_in_wide_band, fb_in_tight_band, over_temp, bias_lockout,
                     enable_in};
  pin_sync #(.W(8)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .bus(sbus.sync)
  );
  wire en_s = sbus.clean[0];
  wire lock_s = sbus.clean[1];
  wire hot_s = sbus.clean[2];
  wire tight_s = sbus.clean[3];
  wire wide_s = sbus.clean[4];
  wire ov_s = sbus.clean[5];
  wire uv_s = sbus.clean[6];
  wire oc_s = sbus.clean[7];

  ////////////////////////////////////////////////////////////////
  // sequencer
  buck_fault_pkg::seq_state_t st_r, st_nxt;
  logic [CW-1:0] ss_cnt_r, uvb_cnt_r, uvd_cnt_r, pgr_cnt_r, pgf_cnt_r;
  logic [CW-1:0] ss_cnt_nxt, uvb_cnt_nxt, uvd_cnt_nxt, pgr_cnt_nxt, pgf_cnt_nxt;
  logic pg_r, pg_nxt;
  logic hs_r, ls_r, sw_on_r;

  wire reset_req = !en_s || lock_s;
  wire ss_done = (ss_cnt_r == CW'(SS_CYC));
  wire uv_armed = (uvb_cnt_r == CW'(UVB_CYC));
  wire uv_expired = uvd_cnt_r == CW'(UVD_CYC);
  wire pg_fall_due = pgf_cnt_r == CW'(`PG_FALL_CYC - 1);
  wire active = (st_r == buck_fault_pkg::ST_SOFTSTART) || (st_r == buck_fault_pkg::ST_RUN);
  wire may_switch = active && !lock_s && !hot_s;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      buck_fault_pkg::ST_OFF: begin
        if (!reset_req) begin
          st_nxt = buck_fault_pkg::ST_SOFTSTART;
        end
      end
      buck_fault_pkg::ST_SOFTSTART, buck_fault_pkg::ST_RUN: begin
        if (reset_req) begin
          st_nxt = buck_fault_pkg::ST_OFF;
        end else if (ov_s) begin
          st_nxt = buck_fault_pkg::ST_OV_LATCH;
        end else if (uv_expired) begin
          st_nxt = buck_fault_pkg::ST_UV_LATCH;
        end else if (ss_done) begin
          st_nxt = buck_fault_pkg::ST_RUN;
        end
      end
      buck_fault_pkg::ST_OV_LATCH, buck_fault_pkg::ST_UV_LATCH: begin
        if (reset_req) begin
          st_nxt = buck_fault_pkg::ST_OFF;
        end
      end
      default: st_nxt = buck_fault_pkg::ST_OFF;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // timers
  always_comb begin
    ss_cnt_nxt = ss_cnt_r;
    uvb_cnt_nxt = uvb_cnt_r;
    uvd_cnt_nxt = '0;
    if (st_r == buck_fault_pkg::ST_OFF) begin
      ss_cnt_nxt = '0;
      uvb_cnt_nxt = '0;
    end else begin
      if (!ss_done) begin
        ss_cnt_nxt = ss_cnt_r + CW'(1);
      end
      if (!uv_armed) begin
        uvb_cnt_nxt = uvb_cnt_r + CW'(1);
      end
    end
    if (active && uv_armed && uv_s && !uv_expired) begin
      uvd_cnt_nxt = uvd_cnt_r + CW'(1);
    end else if (active && uv_armed && uv_s) begin
      uvd_cnt_nxt = uvd_cnt_r;
    end
  end

  assign ref_level = ss_done ? {REF_W{1'b1}}
                             : REF_W'((ss_cnt_r * ((1 << REF_W) - 1)) / SS_CYC);

  ////////////////////////////////////////////////////////////////
  // power-good
  wire pg_enable = (st_r == buck_fault_pkg::ST_RUN);
  always_comb begin
    pg_nxt = pg_r;
    pgr_cnt_nxt = '0;
    pgf_cnt_nxt = '0;
    if (!pg_enable) begin
      pg_nxt = 1'b0;
    end else if (!pg_r) begin
      if (tight_s) begin
        pgr_cnt_nxt = pgr_cnt_r + CW'(1);
        if (pgr_cnt_r == CW'(PGR_CYC - 1)) begin
          pg_nxt = 1'b1;
        end
      end
    end else if (!wide_s) begin
      pgf_cnt_nxt = pgf_cnt_r + CW'(1);
      if (pg_fall_due) begin
        pg_nxt = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // drivers
  wire oc_hold = oc_s && !hs_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_on_r <= 1'b0;
    end else if (!may_switch) begin
      sw_on_r <= 1'b0;
    end else if (pwm_set_req && !oc_hold) begin
      sw_on_r <= 1'b1;
    end else begin
      sw_on_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_r <= 1'b0;
      ls_r <= 1'b0;
    end else if (st_r == buck_fault_pkg::ST_OV_LATCH) begin
      hs_r <= 1'b0;
      ls_r <= 1'b1;
    end else if (!may_switch) begin
      hs_r <= 1'b0;
      ls_r <= 1'b0;
    end else begin
      hs_r <= sw_on_r;
      ls_r <= !sw_on_r;
    end
  end

  assign high_side_gate_drive = hs_r;
  assign low_side_gate_drive = ls_r;
  assign discharge_on = (st_r == buck_fault_pkg::ST_OFF) && !en_s;
  assign offtime_extend = may_switch && oc_hold && pwm_set_req;
  assign on_cycle_start = sw_on_r;
  assign output_in_window_flag_o = 1'b0;
  assign output_in_window_flag_oe = !pg_r;

  ////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= buck_fault_pkg::ST_OFF;
      ss_cnt_r <= '0;
      uvb_cnt_r <= '0;
      uvd_cnt_r <= '0;
      pgr_cnt_r <= '0;
      pgf_cnt_r <= '0;
      pg_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ss_cnt_r <= ss_cnt_nxt;
      uvb_cnt_r <= uvb_cnt_nxt;
      uvd_cnt_r <= uvd_cnt_nxt;
      pgr_cnt_r <= pgr_cnt_nxt;
      pgf_cnt_r <= pgf_cnt_nxt;
      pg_r <= pg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // events, status and mask
  logic [`EV_N-1:0] stat_r, mask_r, ev;
  logic [31:0] rdata_r;
  always_comb begin
    ev = '0;
    ev[`EV_OV] = (st_nxt == buck_fault_pkg::ST_OV_LATCH) && (st_r != buck_fault_pkg::ST_OV_LATCH);
    ev[`EV_UV] = (st_nxt == buck_fault_pkg::ST_UV_LATCH) && (st_r != buck_fault_pkg::ST_UV_LATCH);
    ev[`EV_LOCK] = lock_s;
    ev[`EV_HOT] = hot_s;
    ev[`EV_PG_FALL] = pg_r && !pg_nxt;
    ev[`EV_OC] = offtime_extend;
  end

  wire wr_stat = reg_wr && (reg_addr == `REG_STATUS);
  wire wr_mask = reg_wr && (reg_addr == `REG_MASK);
  wire [`EV_N-1:0] clr = wr_stat ? reg_wdata[`EV_N-1:0] : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= '0;
      mask_r <= '0;
    end else begin
      stat_r <= (stat_r & ~clr) | ev;
      if (wr_mask) begin
        mask_r <= reg_wdata[`EV_N-1:0];
      end
    end
  end

  assign irq = |(stat_r & mask_r);

  wire [31:0] state_word = {22'h0, pg_r, oc_s, hot_s, lock_s, en_s, hs_r, ls_r, st_r};
  wire [31:0] rd_mux = (reg_addr == `REG_STATUS) ? {26'h0, stat_r} :
                       (reg_addr == `REG_MASK) ? {26'h0, mask_r} :
                       (reg_addr == `REG_STATE) ? state_word : 32'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= 32'h0;
    end
  end
  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////
  // check helpers: cycles in band before a rise, out of band before a fall
  logic [CW-1:0] in_band_cnt_r, out_band_cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_band_cnt_r <= '0;
      out_band_cnt_r <= '0;
    end else begin
      in_band_cnt_r <= (pg_enable && !pg_r && tight_s) ? in_band_cnt_r + CW'(1) : '0;
      out_band_cnt_r <= (pg_enable && pg_r && !wide_s) ? out_band_cnt_r + CW'(1) : '0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  property p_pg_off_before_run;
    @(posedge clk) disable iff (!rst_n) !pg_enable |=> !pg_r;
  endproperty
  a_pg_off_before_run: assert property (p_pg_off_before_run) else $error("pg high early");

  property p_pg_rise_cause;
    @(posedge clk) disable iff (!rst_n) $rose(pg_r) |-> in_band_cnt_r == CW'(PGR_CYC);
  endproperty
  a_pg_rise_cause: assert property (p_pg_rise_cause) else $error("pg rise delay wrong");

  property p_pg_fall;
    @(posedge clk) disable iff (!rst_n)
      $fell(pg_r) && pg_enable |-> out_band_cnt_r == CW'(`PG_FALL_CYC);
  endproperty
  a_pg_fall: assert property (p_pg_fall) else $error("pg fell early");

  property p_pg_fall_late;
    @(posedge clk) disable iff (!rst_n) out_band_cnt_r <= CW'(`PG_FALL_CYC);
  endproperty
  a_pg_fall_late: assert property (p_pg_fall_late) else $error("pg fall late");

  property p_pg_od;
    @(posedge clk) disable iff (!rst_n) output_in_window_flag_o == 1'b0;
  endproperty
  a_pg_od: assert property (p_pg_od) else $error("pg driven high");

  property p_ov_latch;
    @(posedge clk) disable iff (!rst_n)
      st_r == buck_fault_pkg::ST_OV_LATCH |=> !hs_r && ls_r;
  endproperty
  a_ov_latch: assert property (p_ov_latch) else $error("ov drivers wrong");

  property p_uv_latch;
    @(posedge clk) disable iff (!rst_n)
      st_r == buck_fault_pkg::ST_UV_LATCH |=> !hs_r && !ls_r;
  endproperty
  a_uv_latch: assert property (p_uv_latch) else $error("uv drivers on");

  property p_uv_blank;
    @(posedge clk) disable iff (!rst_n)
      !uv_armed |-> uvd_cnt_r == '0;
  endproperty
  a_uv_blank: assert property (p_uv_blank) else $error("uv counted early");

  property p_nonlatch;
    @(posedge clk) disable iff (!rst_n) (lock_s || hot_s) |=> !hs_r;
  endproperty
  a_nonlatch: assert property (p_nonlatch) else $error("switching in lockout");

  // enable low long enough for the state and drivers to settle
  sequence s_en_low_settled;
    !en_s [*3];
  endsequence

  property p_discharge;
    @(posedge clk) disable iff (!rst_n)
      s_en_low_settled |-> discharge_on && !hs_r && !ls_r;
  endproperty
  a_discharge: assert property (p_discharge) else $error("no discharge");
endmodule

// ==== verilog/pin_sync.sv ====
`include "buck_fault_defines.svh"
module pin_sync #(
  parameter int W = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  sync_bus_if.sync bus
);
  logic [W-1:0] s1_r, s2_r, s3_r, clean_r;

  ////////////////////////////////////////////////////////////////
  // three stages; a change counts once stage two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          s3_r[i] <= 1'b0;
          clean_r[i] <= 1'b0;
        end else begin
          s1_r[i] <= bus.raw[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            clean_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

  assign bus.clean = clean_r;
endmodule

// ==== verilog/sync_bus_if.sv ====
interface sync_bus_if #(parameter int W = 7);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport owner (output raw, input clean);
  modport sync (input raw, output clean);
endinterface
